/* File: picp_top.sv */
// Pulse input counter pair on an eight channel input module
//
// Contract
// - Offer two 16-bit up, two 16-bit down, or one cascaded 32-bit down counter.
// - Up counter spans 0 to 65535, adds one per accepted pulse.
// - Up counter wraps from its limit to zero and keeps counting.
// - Up counter overflow sets its status bit in the input image.
// - In up mode the output image counter outputs always stay cleared.
// - Up mode: counter-clear rising edge zeroes count and clears status.
// - Output-clear rising edge clears status, count untouched, both modes.
// - Pause rising edge stops counting; counting resumes after its falling edge.
// - Clear controls still act while pause is asserted.
// - Down counter spans 65535 to zero, loads setpoint on start.
// - Down mode: each accepted pulse subtracts one.
// - Down counter at zero sets status, reloads setpoint, keeps counting.
// - Down mode: counter-clear rising edge restores setpoint and clears status.
// - Down mode: pause rising edge also clears the status bit.
// - Controller writes setpoint; device adopts it only on start, clear or zero.
// - Controls from output image; with pin config also from spare channels.
// - Cascaded counter spans 32 bits down, second channel without function.
// - Pin config: channels 2-3 pause, 4-5 clear count, 6-7 clear output.
`default_nettype none
module picp_top (
	// Clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        nrst_i,
	// Field input channels
	input  wire logic [picp_pkg::PIN_N-1:0]  pin_i,
	// Register port
	input  wire logic [picp_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [picp_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [picp_pkg::DATA_W-1:0] rdata_o,
	// Counter status outputs of the input image
	output logic      [1:0]                  stat_o
);
	localparam int unsigned DW = picp_pkg::DATA_W;
	localparam int unsigned CW = picp_pkg::CNT_W;

	// Pin synchroniser; first stage feeds only the second
	logic [picp_pkg::PIN_N-1:0] pin_meta;
	logic [picp_pkg::PIN_N-1:0] pin_sync;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta;
		end
	end

	// Software registers
	logic [1:0]                  cfg_mode;
	logic                        cfg_pinctl;
	logic [picp_pkg::CTRL_W-1:0] ctrl;
	logic [CW-1:0]               sp1;
	logic [CW-1:0]               sp2;
	logic                        start;

	wire sel_cfg  = (addr_i == picp_pkg::OFS_CFG);
	wire sel_ctrl = (addr_i == picp_pkg::OFS_CTRL);
	wire sel_sp1  = (addr_i == picp_pkg::OFS_SP1);
	wire sel_sp2  = (addr_i == picp_pkg::OFS_SP2);
	wire sel_cnt1 = (addr_i == picp_pkg::OFS_CNT1);
	wire sel_cnt2 = (addr_i == picp_pkg::OFS_CNT2);
	wire sel_stat = (addr_i == picp_pkg::OFS_STAT);
	wire sel_pins = (addr_i == picp_pkg::OFS_PINS);

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_mode   <= picp_pkg::RST_MODE;
			cfg_pinctl <= picp_pkg::RST_PINCTL;
			ctrl       <= picp_pkg::RST_CTRL;
			sp1        <= picp_pkg::RST_SP;
			sp2        <= picp_pkg::RST_SP;
			start      <= 1'b0;
		end else begin
			// Any configuration write restarts the counters
			start <= wr_i & sel_cfg;
			if (wr_i && sel_cfg) begin
				cfg_mode   <= wdata_i[picp_pkg::CFG_MODE_LSB +: 2];
				cfg_pinctl <= wdata_i[picp_pkg::CFG_PINCTL];
			end
			if (wr_i && sel_ctrl) begin
				ctrl <= wdata_i[picp_pkg::CTRL_W-1:0];
			end
			if (wr_i && sel_sp1) begin
				sp1 <= wdata_i[CW-1:0];
			end
			if (wr_i && sel_sp2) begin
				sp2 <= wdata_i[CW-1:0];
			end
		end
	end

	// Mode decode
	wire en16   = (cfg_mode == picp_pkg::MODE_UP16) || (cfg_mode == picp_pkg::MODE_DOWN16);
	wire down16 = (cfg_mode == picp_pkg::MODE_DOWN16);
	wire en32   = (cfg_mode == picp_pkg::MODE_DOWN32);

	// Control levels: image bit ORed with the spare channel when pin config is set
	wire [1:0] pin_gate = cfg_pinctl ? 2'h3 : 2'h0;
	wire [1:0] pause_lvl  = ctrl[picp_pkg::CTRL_PAUSE_LSB +: 2]
		| (pin_sync[picp_pkg::PIN_PAUSE_LSB +: 2] & pin_gate);
	wire [1:0] clrcnt_lvl = ctrl[picp_pkg::CTRL_CLRCNT_LSB +: 2]
		| (pin_sync[picp_pkg::PIN_CLRCNT_LSB +: 2] & pin_gate);
	wire [1:0] clrout_lvl = ctrl[picp_pkg::CTRL_CLROUT_LSB +: 2]
		| (pin_sync[picp_pkg::PIN_CLROUT_LSB +: 2] & pin_gate);
	wire [1:0] cnt_lvl    = pin_sync[picp_pkg::PIN_CNT_LSB +: 2];

	logic [7:0] rise;
	logic [7:0] fall;

	picp_edge #(
		.W (8)
	) u_edge (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.lvl_i  ({clrout_lvl, clrcnt_lvl, pause_lvl, cnt_lvl}),
		.rise_o (rise),
		.fall_o (fall)
	);

	wire [1:0] cnt_rise    = rise[1:0];
	wire [1:0] pause_rise  = rise[3:2];
	wire [1:0] pause_fall  = fall[3:2];
	wire [1:0] clrcnt_rise = rise[5:4];
	wire [1:0] clrout_rise = rise[7:6];

	// Two 16-bit slices and one cascaded slice
	logic [CW-1:0]                cnt_a;
	logic [CW-1:0]                cnt_b;
	logic [picp_pkg::CASC_W-1:0]  cnt_c;
	logic [2:0]                   st;
	logic [2:0]                   pz;

	picp_cnt #(
		.W (CW)
	) u_cnt_a (
		.mclk_i       (mclk_i),
		.nrst_i       (nrst_i),
		.en_i         (en16),
		.down_i       (down16),
		.start_i      (start),
		.setpoint_i   (sp1),
		.pulse_i      (cnt_rise[0]),
		.pause_rise_i (pause_rise[0]),
		.pause_fall_i (pause_fall[0]),
		.clr_cnt_i    (clrcnt_rise[0]),
		.clr_out_i    (clrout_rise[0]),
		.count_o      (cnt_a),
		.status_o     (st[0]),
		.paused_o     (pz[0])
	);

	picp_cnt #(
		.W (CW)
	) u_cnt_b (
		.mclk_i       (mclk_i),
		.nrst_i       (nrst_i),
		.en_i         (en16),
		.down_i       (down16),
		.start_i      (start),
		.setpoint_i   (sp2),
		.pulse_i      (cnt_rise[1]),
		.pause_rise_i (pause_rise[1]),
		.pause_fall_i (pause_fall[1]),
		.clr_cnt_i    (clrcnt_rise[1]),
		.clr_out_i    (clrout_rise[1]),
		.count_o      (cnt_b),
		.status_o     (st[1]),
		.paused_o     (pz[1])
	);

	// Cascade uses channel 0 and the counter 1 controls only
	picp_cnt #(
		.W (picp_pkg::CASC_W)
	) u_cnt_c (
		.mclk_i       (mclk_i),
		.nrst_i       (nrst_i),
		.en_i         (en32),
		.down_i       (1'b1),
		.start_i      (start),
		.setpoint_i   ({sp2, sp1}),
		.pulse_i      (cnt_rise[0]),
		.pause_rise_i (pause_rise[0]),
		.pause_fall_i (pause_fall[0]),
		.clr_cnt_i    (clrcnt_rise[0]),
		.clr_out_i    (clrout_rise[0]),
		.count_o      (cnt_c),
		.status_o     (st[2]),
		.paused_o     (pz[2])
	);

	// Input image view
	wire [1:0]    out_bits   = en32 ? {1'b0, st[2]} : st[1:0];
	wire [1:0]    pause_bits = en32 ? {1'b0, pz[2]} : pz[1:0];
	// Output image counter outputs are never set by the device
	wire [1:0]    img_bits   = 2'h0;
	wire [CW-1:0] cnt1_view  = en32 ? cnt_c[CW-1:0] : cnt_a;
	wire [CW-1:0] cnt2_view  = en32 ? cnt_c[picp_pkg::CASC_W-1:CW] : cnt_b;

	wire [DW-1:0] rd_cfg  = DW'({cfg_pinctl, cfg_mode});
	wire [DW-1:0] rd_stat = DW'({pause_bits, img_bits, out_bits});
	wire [DW-1:0] rd_mux  =
		sel_cfg  ? rd_cfg :
		sel_ctrl ? DW'(ctrl) :
		sel_sp1  ? DW'(sp1) :
		sel_sp2  ? DW'(sp2) :
		sel_cnt1 ? DW'(cnt1_view) :
		sel_cnt2 ? DW'(cnt2_view) :
		sel_stat ? rd_stat :
		sel_pins ? DW'(pin_sync) :
		'0;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= '0;
			stat_o  <= 2'h0;
		end else begin
			// Read data valid only in the cycle after the strobe
			rdata_o <= rd_i ? rd_mux : '0;
			stat_o  <= out_bits;
		end
	end
endmodule
`default_nettype wire

/* File: picp_pkg.sv */
// Constants shared by the pulse input counter pair
`default_nettype none
package picp_pkg;
	// Register bus geometry
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned CNT_W       = 16;
	localparam int unsigned CASC_W      = 32;
	localparam int unsigned PIN_N       = 8;
	// Register byte offsets
	localparam logic [7:0]  OFS_CFG     = 8'h00;
	localparam logic [7:0]  OFS_CTRL    = 8'h04;
	localparam logic [7:0]  OFS_SP1     = 8'h08;
	localparam logic [7:0]  OFS_SP2     = 8'h0C;
	localparam logic [7:0]  OFS_CNT1    = 8'h10;
	localparam logic [7:0]  OFS_CNT2    = 8'h14;
	localparam logic [7:0]  OFS_STAT    = 8'h18;
	localparam logic [7:0]  OFS_PINS    = 8'h1C;
	// Configuration register fields
	localparam int unsigned CFG_MODE_LSB  = 0;
	localparam int unsigned CFG_PINCTL    = 2;
	localparam logic [1:0]  MODE_UP16     = 2'h0;
	localparam logic [1:0]  MODE_DOWN16   = 2'h1;
	localparam logic [1:0]  MODE_DOWN32   = 2'h2;
	localparam logic [1:0]  MODE_OFF      = 2'h3;
	// Control register fields, two bits each, counter 1 in the lower bit
	localparam int unsigned CTRL_PAUSE_LSB  = 0;
	localparam int unsigned CTRL_CLRCNT_LSB = 2;
	localparam int unsigned CTRL_CLROUT_LSB = 4;
	localparam int unsigned CTRL_W          = 6;
	// Input channel roles
	localparam int unsigned PIN_CNT_LSB     = 0;
	localparam int unsigned PIN_PAUSE_LSB   = 2;
	localparam int unsigned PIN_CLRCNT_LSB  = 4;
	localparam int unsigned PIN_CLROUT_LSB  = 6;
	// Status register fields
	localparam int unsigned STAT_OUT_LSB    = 0;
	localparam int unsigned STAT_IMG_LSB    = 2;
	localparam int unsigned STAT_PAUSE_LSB  = 4;
	// Reset values
	localparam logic [1:0]        RST_MODE  = MODE_UP16;
	localparam logic              RST_PINCTL = 1'b0;
	localparam logic [CTRL_W-1:0] RST_CTRL  = 6'h00;
	localparam logic [CNT_W-1:0]  RST_SP    = 16'h0000;
endpackage
`default_nettype wire

/* File: picp_edge.sv */
// Rising and falling edge detector for a group of synchronous levels
`default_nettype none
module picp_edge #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         nrst_i,
	// Levels in, one-cycle edge pulses out
	input  wire logic [W-1:0] lvl_i,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] prev;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prev <= '0;
		end else begin
			prev <= lvl_i;
		end
	end

	// One pulse per transition
	assign rise_o = lvl_i & ~prev;
	assign fall_o = ~lvl_i & prev;
endmodule
`default_nettype wire

/* File: picp_cnt.sv */
// One counter slice: up with wrap or periodic down with setpoint reload
`default_nettype none
module picp_cnt #(
	parameter int unsigned W = 16
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         nrst_i,
	// Mode
	input  wire logic         en_i,
	input  wire logic         down_i,
	input  wire logic         start_i,
	input  wire logic [W-1:0] setpoint_i,
	// Edge pulses
	input  wire logic         pulse_i,
	input  wire logic         pause_rise_i,
	input  wire logic         pause_fall_i,
	input  wire logic         clr_cnt_i,
	input  wire logic         clr_out_i,
	// State
	output logic      [W-1:0] count_o,
	output logic              status_o,
	output logic              paused_o
);
	localparam logic [W-1:0] ONE = W'(1);
	localparam logic [W-1:0] MAX = '1;

	logic [W-1:0] next_count;
	logic         next_status;
	logic         next_paused;
	logic         accept;
	logic [W-1:0] reload;

	assign reload = down_i ? setpoint_i : '0;
	// The pausing edge itself already blocks a pulse
	assign accept = pulse_i & ~paused_o & ~pause_rise_i;

	always_comb begin
		next_paused = paused_o;
		if (pause_rise_i) begin
			next_paused = 1'b1;
		end else if (pause_fall_i) begin
			next_paused = 1'b0;
		end
		next_count  = count_o;
		next_status = status_o;
		if (!en_i) begin
			next_count  = '0;
			next_status = 1'b0;
			next_paused = 1'b0;
		end else if (start_i) begin
			next_count  = reload;
			next_status = 1'b0;
		end else if (clr_cnt_i) begin
			// Acts regardless of pause
			next_count  = reload;
			next_status = 1'b0;
		end else begin
			if (clr_out_i || (down_i && pause_rise_i)) begin
				next_status = 1'b0;
			end
			if (accept && !down_i) begin
				next_count = count_o + ONE;
				if (count_o == MAX) begin
					next_status = 1'b1;
				end
			end else if (accept) begin
				if (count_o <= ONE) begin
					next_count  = setpoint_i;
					next_status = 1'b1;
				end else begin
					next_count = count_o - ONE;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count_o  <= '0;
			status_o <= 1'b0;
			paused_o <= 1'b0;
		end else begin
			count_o  <= next_count;
			status_o <= next_status;
			paused_o <= next_paused;
		end
	end
endmodule
`default_nettype wire

/* File: picp_asserts.sv */
// Port checker for the pulse input counter pair
`default_nettype none
module picp_asserts (
	input wire logic        mclk_i,
	input wire logic        nrst_i,
	input wire logic [7:0]  pin_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [1:0]  stat_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	chk_rd_data_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not idle");
	chk_img_out_zero: assert property (
		rd_i && addr_i == 8'h18 |=> rdata_o[3:2] == 2'h0)
		else $error("output image bits set");
	chk_unmapped_zero: assert property (rd_i && addr_i == 8'h20 |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	chk_mode_readback: assert property (
		wr_i && addr_i == 8'h00 ##1 rd_i && addr_i == 8'h00
		|=> rdata_o[2:0] == $past(wdata_i[2:0], 2))
		else $error("mode readback wrong");
	chk_sp_readback: assert property (
		wr_i && addr_i == 8'h08 ##1 rd_i && addr_i == 8'h08
		|=> rdata_o[15:0] == $past(wdata_i[15:0], 2))
		else $error("setpoint readback wrong");
	chk_pins_synced: assert property (
		$stable(pin_i) [*4] ##1 (rd_i && addr_i == 8'h1C) |=> rdata_o[7:0] == $past(pin_i, 3))
		else $error("pin levels wrong");
	chk_stat0_cause: assert property ($rose(stat_o[0]) |-> $past(pin_i[0], 3))
		else $error("status 1 set without pulse");
	chk_stat1_cause: assert property ($rose(stat_o[1]) |-> $past(pin_i[1], 3))
		else $error("status 2 set without pulse");
endmodule
bind picp_top picp_asserts i_picp_asserts (.mclk_i(mclk_i), .nrst_i(nrst_i), .pin_i(pin_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.stat_o(stat_o));
`default_nettype wire

/* File: picp_ctl_model.sv */
// Controller model: writes the output image, reads the input image
`default_nettype none
module picp_ctl_model (
	input  wire logic        mclk_i,
	input  wire logic [31:0] rdata_i,
	output var logic  [7:0]  addr_o,
	output var logic  [31:0] wdata_o,
	output var logic         wr_o,
	output var logic         rd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Control register writes only ever come from here; setpoint 1 and config are also written by wr_rd_reg
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
	endtask
	// Write then read back with no idle cycle between the strobes
	task automatic wr_rd_reg(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		@(posedge mclk_i);
		q = rdata_i;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		@(posedge mclk_i);
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the pulse input counter pair
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  pin_i = 8'h00;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [1:0]  stat;
	int          bad_count = 0;
	int          samples_checked = 0;
	always #5 mclk_i = ~mclk_i;
	picp_top i_picp_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .pin_i(pin_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .stat_o(stat));
	picp_ctl_model i_picp_ctl_model (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [15:0] d);
		i_picp_ctl_model.wr_reg(a, {16'h0, d});
	endtask
	task automatic r(input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] d;
		i_picp_ctl_model.rd_reg(a, d);
		chk(d[15:0], exp);
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		i_picp_ctl_model.wr_rd_reg(a, {16'h0, d}, q);
		chk(q[15:0], d);
	endtask
	task automatic settle;
		repeat (4) @(posedge mclk_i);
	endtask
	// Held high and low three cycles, above the two-cycle minimum
	task automatic pulse(input int ch);
		@(posedge mclk_i);
		pin_i[ch] <= 1'b1;
		repeat (3) @(posedge mclk_i);
		pin_i[ch] <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask
	task automatic t_up;
		w(8'h00, 16'h0);
		repeat (3) pulse(0);
		w(8'h10, 16'h1234);
		r(8'h10, 16'h0003);
		pulse(1);
		r(8'h14, 16'h0001);
		r(8'h18, 16'h0000);
		pulse(4);
		r(8'h10, 16'h0003);
		w(8'h04, 16'h0004);
		settle;
		r(8'h10, 16'h0000);
		r(8'h20, 16'h0000);
		w(8'h04, 16'h0000);
	endtask
	task automatic t_down;
		w(8'h08, 16'h0003);
		w(8'h0C, 16'h0001);
		w(8'h00, 16'h0001);
		settle;
		r(8'h10, 16'h0003);
		pulse(0);
		wr_rd(8'h08, 16'h0005);
		pulse(0);
		r(8'h10, 16'h0001);
		pulse(0);
		settle;
		chk({14'h0, stat}, 16'h0001);
		r(8'h10, 16'h0005);
		w(8'h04, 16'h0001);
		settle;
		chk({14'h0, stat}, 16'h0000);
		pulse(0);
		r(8'h10, 16'h0005);
		r(8'h18, 16'h0010);
		w(8'h08, 16'h0007);
		w(8'h04, 16'h0005);
		settle;
		r(8'h10, 16'h0007);
		w(8'h04, 16'h0000);
		pulse(0);
		r(8'h10, 16'h0006);
		w(8'h08, 16'h0001);
		w(8'h04, 16'h0004);
		pulse(0);
		settle;
		chk({14'h0, stat}, 16'h0001);
		w(8'h04, 16'h0014);
		settle;
		chk({14'h0, stat}, 16'h0000);
		r(8'h10, 16'h0001);
		w(8'h04, 16'h0000);
		// Counter 2 starts at setpoint 1, so one pulse reaches zero
		pulse(1);
		settle;
		chk({14'h0, stat}, 16'h0002);
	endtask
	task automatic t_casc;
		w(8'h08, 16'h0002);
		w(8'h0C, 16'h0001);
		wr_rd(8'h00, 16'h0002);
		settle;
		r(8'h14, 16'h0001);
		repeat (3) pulse(0);
		pulse(1);
		r(8'h10, 16'hFFFF);
		r(8'h14, 16'h0000);
		chk({14'h0, stat}, 16'h0000);
		w(8'h00, 16'h0003);
		pulse(0);
		r(8'h10, 16'h0000);
	endtask
	task automatic t_pins;
		w(8'h00, 16'h0004);
		repeat (2) pulse(0);
		@(posedge mclk_i);
		pin_i[2] <= 1'b1;
		settle;
		pulse(0);
		r(8'h10, 16'h0002);
		pulse(4);
		r(8'h10, 16'h0000);
		w(8'h04, 16'h0001);
		@(posedge mclk_i);
		pin_i[2] <= 1'b0;
		settle;
		pulse(0);
		r(8'h10, 16'h0000);
		w(8'h04, 16'h0000);
		pulse(0);
		r(8'h10, 16'h0001);
		@(posedge mclk_i);
		pin_i <= 8'h88;
		settle;
		r(8'h1C, 16'h0088);
	endtask
	// Mid-run reset must bring config, control, setpoint 1, counter 1 and status back to their reset values
	task automatic t_reset;
		@(posedge mclk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		r(8'h00, 16'h0000);
		r(8'h08, 16'h0000);
		r(8'h04, 16'h0000);
		r(8'h10, 16'h0000);
		chk({14'h0, stat}, 16'h0000);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk_i);
		nrst_i <= 1'b1;
		t_up;
		t_down;
		t_casc;
		t_pins;
		t_reset;
		summarize;
	end
	// Whole run needs about 350 cycles
	initial begin
		#200us;
		bad_count++;
		summarize;
	end
endmodule
`default_nettype wire
